// ### emla_array.sv
// Eight-macrocell logic array with Avalon-MM register access
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Registers clear at power-up, registered outputs high
// - Preload forces each register high or low
// - Security blocks pattern readback and preload
// - 64-bit signature always readable and writable
// - Eight macrocells, four configurable cell types
// - Registered mode: clock, enable pins not inputs
// - Complex mode: clock, enable on outer feedback
// - Simple mode: inner cells always outputs, no feedback
// - Undriven inputs and I/Os read high
// - Registered mode clocking, enable, term split
// - Complex mode seven sum terms, one enable
// - Simple mode eight sum terms, no enable
module emla_array import emla_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [EMLA_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [EMLA_INPUTS-1:0] in_pin,
  input wire logic [EMLA_INPUTS-1:0] in_pin_driven,
  input wire logic clk_pin,
  input wire logic clk_pin_driven,
  input wire logic oe_n_pin,
  input wire logic oe_n_pin_driven,
  input wire logic [EMLA_CELLS-1:0] io_pin_in,
  input wire logic [EMLA_CELLS-1:0] io_pin_driven,
  output logic [EMLA_CELLS-1:0] io_pin_out,
  output logic [EMLA_CELLS-1:0] io_pin_oe
);

  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic oe_s1;
    logic oe_s2;
    logic [EMLA_INPUTS-1:0] in_s1;
    logic [EMLA_INPUTS-1:0] in_s2;
    logic [EMLA_CELLS-1:0] io_s1;
    logic [EMLA_CELLS-1:0] io_s2;
    logic [EMLA_PUR_CW-1:0] pur_cnt;
    logic ready;
    emla_mode_t mode;
    logic [EMLA_CELLS-1:0][1:0] cell_type;
    logic [EMLA_CELLS-1:0] pol;
    logic secure;
    logic [EMLA_SIG_W-1:0] sig;
    logic [EMLA_TERM_AW-1:0] arr_addr;
    logic [EMLA_CELLS-1:0] mcr;
    logic [EMLA_TERM_AW-1:0] idx;
    logic rd_vld;
    logic [EMLA_TERM_AW-1:0] rd_idx;
    logic [EMLA_COLS-1:0] snap;
    logic [EMLA_CELLS-1:0] acc_sum;
    logic [EMLA_CELLS-1:0] acc_en;
    logic [EMLA_CELLS-1:0] sum;
    logic [EMLA_CELLS-1:0] en;
    logic [EMLA_CELLS-1:0] out;
    logic [EMLA_CELLS-1:0] oe;
    logic ack;
    logic [31:0] rdata;
  } emla_state_t;

  if (EMLA_PUR_CYC >= (1 << EMLA_PUR_CW) || EMLA_PUR_CYC < 1) begin : g_chk
    $error("emla_array: power-up count does not fit its counter");
  end

  emla_state_t s_q;
  emla_state_t s_d;
  logic [EMLA_TERM_W-1:0] mem_rdata;
  logic mem_we;
  logic steal;
  logic [EMLA_TERM_AW-1:0] mem_addr;

  function automatic logic term_eval(logic [EMLA_TERM_W-1:0] f,
                                     logic [EMLA_COLS-1:0] col);
    logic [EMLA_TERM_W-1:0] lit;
    lit = '0;
    for (int k = 0; k < EMLA_COLS; k++) begin
      lit[2*k] = col[k];
      lit[2*k+1] = ~col[k];
    end
    // Blank term is held false
    return (|f) && (&(~f | lit));
  endfunction : term_eval

  function automatic logic is_reg(emla_mode_t m, logic [1:0] t);
    return (m == EMLA_MODE_REG) && (t == EMLA_CELL_REG);
  endfunction : is_reg

  function automatic logic uses_en(emla_mode_t m, logic [1:0] t);
    logic r;
    r = 1'b0;
    unique case (m)
      EMLA_MODE_REG: r = (t != EMLA_CELL_REG);
      EMLA_MODE_COMPLEX: r = 1'b1;
      EMLA_MODE_SIMPLE: r = 1'b0;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : uses_en

  function automatic logic [31:0] be_merge(logic [31:0] old,
                                           logic [31:0] nw,
                                           logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : be_merge

  emla_term_mem #(
    .W(EMLA_TERM_W),
    .D(EMLA_TERMS),
    .AW(EMLA_TERM_AW)
  ) u_mem (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(avs_writedata),
    .rdata_q(mem_rdata)
  );

  always_comb begin
    logic [EMLA_CELLS-1:0] io_eff;
    logic [EMLA_COLS-1:0] cols;
    logic [EMLA_CELLS-1:0] acc_sum;
    logic [EMLA_CELLS-1:0] acc_en;
    logic [31:0] cur;
    logic [31:0] wv;
    logic [2:0] mc;
    logic v;
    logic edge_clk;
    logic req;
    logic wr_now;
    io_eff = '0;
    cols = '0;
    acc_sum = s_q.acc_sum;
    acc_en = s_q.acc_en;
    cur = '0;
    wv = '0;
    mc = s_q.rd_idx[5:3];
    v = 1'b0;
    edge_clk = 1'b0;
    req = 1'b0;
    wr_now = 1'b0;
    s_d = s_q;

    // Pin sampling with weak pull-ups
    for (int k = 0; k < EMLA_CELLS; k++) begin
      io_eff[k] = s_q.oe[k] ? s_q.out[k]
                : (io_pin_driven[k] ? io_pin_in[k] : 1'b1);
    end
    s_d.clk_s1 = clk_pin_driven ? clk_pin : 1'b1;
    s_d.oe_s1 = oe_n_pin_driven ? oe_n_pin : 1'b1;
    s_d.in_s1 = in_pin | ~in_pin_driven;
    s_d.io_s1 = io_eff;
    s_d.clk_s2 = s_q.clk_s1;
    s_d.clk_s3 = s_q.clk_s2;
    s_d.oe_s2 = s_q.oe_s1;
    s_d.in_s2 = s_q.in_s1;
    s_d.io_s2 = s_q.io_s1;

    // Power-up interval; clock edges ignored until it ends
    if (!s_q.ready) begin
      s_d.pur_cnt = s_q.pur_cnt + 1'b1;
      if (s_q.pur_cnt == EMLA_PUR_CW'(EMLA_PUR_CYC - 1)) begin
        s_d.ready = 1'b1;
      end
    end
    edge_clk = s_q.clk_s2 & ~s_q.clk_s3 & s_q.ready;

    // Bus handshake: one wait cycle, action at the accept edge
    req = avs_read | avs_write;
    s_d.ack = req & ~s_q.ack;
    wr_now = s_q.ack & avs_write;

    // Array columns per mode
    for (int k = 0; k < EMLA_INPUTS; k++) begin
      cols[k] = s_q.in_s2[k];
    end
    for (int k = 0; k < EMLA_CELLS; k++) begin
      unique case (s_q.mode)
        EMLA_MODE_REG: begin
          cols[EMLA_INPUTS+k] = is_reg(s_q.mode, s_q.cell_type[k])
                              ? s_q.mcr[k] : s_q.io_s2[k];
        end
        EMLA_MODE_COMPLEX: begin
          if (3'(k) == EMLA_MC_OUTER_LO) begin
            cols[EMLA_INPUTS+k] = s_q.clk_s2;
          end else if (3'(k) == EMLA_MC_OUTER_HI) begin
            cols[EMLA_INPUTS+k] = s_q.oe_s2;
          end else begin
            cols[EMLA_INPUTS+k] = s_q.io_s2[k];
          end
        end
        EMLA_MODE_SIMPLE: begin
          if (3'(k) == EMLA_MC_INNER_LO) begin
            cols[EMLA_INPUTS+k] = s_q.clk_s2;
          end else if (3'(k) == EMLA_MC_INNER_HI) begin
            cols[EMLA_INPUTS+k] = s_q.oe_s2;
          end else begin
            cols[EMLA_INPUTS+k] = s_q.io_s2[k];
          end
        end
        default: cols[EMLA_INPUTS+k] = s_q.io_s2[k];
      endcase
    end

    // Term sweep, one term per cycle
    s_d.rd_vld = ~steal;
    s_d.rd_idx = s_q.idx;
    if (!steal) begin
      s_d.idx = s_q.idx + 1'b1;
    end
    if (s_q.rd_vld) begin
      v = term_eval(mem_rdata, s_q.snap);
      if (s_q.rd_idx[2:0] == EMLA_ROW_ENABLE &&
          uses_en(s_q.mode, s_q.cell_type[mc])) begin
        acc_en[mc] = v;
      end else begin
        acc_sum[mc] = acc_sum[mc] | v;
      end
      if (s_q.rd_idx == EMLA_LAST_TERM) begin
        s_d.sum = acc_sum;
        s_d.en = acc_en;
        acc_sum = '0;
        acc_en = '0;
        s_d.snap = cols;
      end
    end
    s_d.acc_sum = acc_sum;
    s_d.acc_en = acc_en;

    // Macrocell registers: shared clock, preload, power-up clear
    for (int k = 0; k < EMLA_CELLS; k++) begin
      if (edge_clk && is_reg(s_q.mode, s_q.cell_type[k])) begin
        s_d.mcr[k] = s_q.sum[k];
      end
    end
    if (wr_now && avs_address == EMLA_OFF_PLOAD && !s_q.secure) begin
      for (int k = 0; k < EMLA_CELLS; k++) begin
        if (avs_writedata[EMLA_PL_MASK_LSB+k]) begin
          s_d.mcr[k] = avs_writedata[k];
        end
      end
    end
    if (!s_q.ready) begin
      s_d.mcr = '0;
    end

    // Pin drivers per cell type
    for (int k = 0; k < EMLA_CELLS; k++) begin
      if (is_reg(s_q.mode, s_q.cell_type[k])) begin
        s_d.out[k] = ~s_q.mcr[k];
        s_d.oe[k] = ~s_q.oe_s2;
      end else begin
        s_d.out[k] = s_q.sum[k] ^ s_q.pol[k];
        if (s_q.mode == EMLA_MODE_SIMPLE &&
            (3'(k) == EMLA_MC_INNER_LO || 3'(k) == EMLA_MC_INNER_HI)) begin
          s_d.oe[k] = 1'b1;
        end else if (s_q.cell_type[k] == EMLA_CELL_INPUT) begin
          s_d.oe[k] = 1'b0;
        end else if (s_q.mode == EMLA_MODE_SIMPLE) begin
          s_d.oe[k] = 1'b1;
        end else begin
          s_d.oe[k] = s_q.en[k];
        end
      end
      if (!s_q.ready) begin
        s_d.oe[k] = 1'b0;
      end
    end

    // Register reads, captured in the wait cycle
    if (req && !s_q.ack) begin
      unique case (avs_address)
        EMLA_OFF_CTRL: begin
          cur = 32'(s_q.mode);
          cur[EMLA_CTRL_SECURE_BIT] = s_q.secure;
        end
        EMLA_OFF_CELLCFG: begin
          cur = 32'(s_q.cell_type);
          cur[EMLA_CFG_POL_LSB +: EMLA_CELLS] = s_q.pol;
        end
        EMLA_OFF_PLOAD: cur = 32'(s_q.mcr);
        EMLA_OFF_STATUS: begin
          cur[EMLA_ST_READY_BIT] = s_q.ready;
          cur[EMLA_ST_SECURE_BIT] = s_q.secure;
          cur[EMLA_ST_OUT_LSB +: EMLA_CELLS] = s_q.out;
          cur[EMLA_ST_OE_LSB +: EMLA_CELLS] = s_q.oe;
        end
        EMLA_OFF_SIG_LO: cur = s_q.sig[31:0];
        EMLA_OFF_SIG_HI: cur = s_q.sig[63:32];
        EMLA_OFF_ARR_ADDR: cur = 32'(s_q.arr_addr);
        default: cur = '0;
      endcase
      s_d.rdata = cur;
    end

    // Register writes at the accept edge
    if (wr_now) begin
      unique case (avs_address)
        EMLA_OFF_CTRL: begin
          wv = be_merge(32'(s_q.mode), avs_writedata, avs_byteenable);
          if (wv[1:0] != 2'b11) begin
            s_d.mode = emla_mode_t'(wv[1:0]);
          end
          if (avs_byteenable[1] && avs_writedata[EMLA_CTRL_SECURE_BIT]) begin
            s_d.secure = 1'b1;
          end
        end
        EMLA_OFF_CELLCFG: begin
          cur = 32'(s_q.cell_type);
          cur[EMLA_CFG_POL_LSB +: EMLA_CELLS] = s_q.pol;
          wv = be_merge(cur, avs_writedata, avs_byteenable);
          s_d.cell_type = wv[15:0];
          s_d.pol = wv[EMLA_CFG_POL_LSB +: EMLA_CELLS];
        end
        EMLA_OFF_SIG_LO: begin
          s_d.sig[31:0] = be_merge(s_q.sig[31:0], avs_writedata,
                                   avs_byteenable);
        end
        EMLA_OFF_SIG_HI: begin
          s_d.sig[63:32] = be_merge(s_q.sig[63:32], avs_writedata,
                                    avs_byteenable);
        end
        EMLA_OFF_ARR_ADDR: begin
          wv = be_merge(32'(s_q.arr_addr), avs_writedata, avs_byteenable);
          s_d.arr_addr = wv[EMLA_TERM_AW-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Bus borrows the term store port; the sweep skips that cycle
  assign mem_we = s_q.ack & avs_write & (avs_address == EMLA_OFF_ARR_DATA);
  assign steal = mem_we | (avs_read & ~s_q.ack &
                           (avs_address == EMLA_OFF_ARR_DATA));
  assign mem_addr = steal ? s_q.arr_addr : s_q.idx;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.clk_s1 <= 1'b1;
      s_q.clk_s2 <= 1'b1;
      s_q.clk_s3 <= 1'b1;
      s_q.oe_s1 <= 1'b1;
      s_q.oe_s2 <= 1'b1;
      s_q.mode <= EMLA_MODE_REG;
      s_q.cell_type <= EMLA_CFG_RESET;
      s_q.pol <= EMLA_POL_RESET;
      s_q.out <= EMLA_OUT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
  assign avs_readdata = (s_q.ack && avs_address == EMLA_OFF_ARR_DATA)
                      ? (s_q.secure ? '0 : mem_rdata)
                      : s_q.rdata;
  assign io_pin_out = s_q.out;
  assign io_pin_oe = s_q.oe;

endmodule : emla_array
`default_nettype wire

// ### emla_pkg.sv
// Shared constants and types of the eight-macrocell logic array
package emla_pkg;

  localparam int EMLA_CELLS = 8;
  localparam int EMLA_INPUTS = 8;
  localparam int EMLA_COLS = 16;
  localparam int EMLA_TERM_W = 32;
  localparam int EMLA_TERMS = 64;
  localparam int EMLA_TERM_AW = 6;
  localparam int EMLA_SIG_W = 64;
  localparam int EMLA_AW = 5;

  localparam logic [EMLA_AW-1:0] EMLA_OFF_CTRL = 5'h00;
  localparam logic [EMLA_AW-1:0] EMLA_OFF_CELLCFG = 5'h04;
  localparam logic [EMLA_AW-1:0] EMLA_OFF_PLOAD = 5'h08;
  localparam logic [EMLA_AW-1:0] EMLA_OFF_STATUS = 5'h0C;
  localparam logic [EMLA_AW-1:0] EMLA_OFF_SIG_LO = 5'h10;
  localparam logic [EMLA_AW-1:0] EMLA_OFF_SIG_HI = 5'h14;
  localparam logic [EMLA_AW-1:0] EMLA_OFF_ARR_ADDR = 5'h18;
  localparam logic [EMLA_AW-1:0] EMLA_OFF_ARR_DATA = 5'h1C;

  localparam int EMLA_CTRL_SECURE_BIT = 8;
  localparam int EMLA_CFG_POL_LSB = 16;
  localparam int EMLA_PL_MASK_LSB = 8;
  localparam int EMLA_ST_READY_BIT = 0;
  localparam int EMLA_ST_SECURE_BIT = 1;
  localparam int EMLA_ST_OUT_LSB = 8;
  localparam int EMLA_ST_OE_LSB = 16;

  localparam logic [7:0] EMLA_OUT_RESET = 8'hFF;
  localparam logic [15:0] EMLA_CFG_RESET = 16'h0000;
  localparam logic [7:0] EMLA_POL_RESET = 8'h00;

  localparam int EMLA_CLK_PERIOD_NS = 10;
  localparam int EMLA_PUR_TIME_NS = 1000;
  localparam int EMLA_PUR_CYC = EMLA_PUR_TIME_NS / EMLA_CLK_PERIOD_NS;
  localparam int EMLA_PUR_CW = 8;

  // Outermost and innermost macrocell positions, enable term row and last term index
  localparam logic [2:0] EMLA_MC_OUTER_LO = 3'h0;
  localparam logic [2:0] EMLA_MC_OUTER_HI = 3'h7;
  localparam logic [2:0] EMLA_MC_INNER_LO = 3'h3;
  localparam logic [2:0] EMLA_MC_INNER_HI = 3'h4;
  localparam logic [2:0] EMLA_ROW_ENABLE = 3'h0;
  localparam logic [5:0] EMLA_LAST_TERM = 6'h3F;

  typedef enum logic [1:0] {
    EMLA_MODE_REG = 2'b00,
    EMLA_MODE_COMPLEX = 2'b01,
    EMLA_MODE_SIMPLE = 2'b10
  } emla_mode_t;

  typedef enum logic [1:0] {
    EMLA_CELL_REG = 2'b00,
    EMLA_CELL_COMB_IO = 2'b01,
    EMLA_CELL_COMB_OUT = 2'b10,
    EMLA_CELL_INPUT = 2'b11
  } emla_cell_t;

endpackage : emla_pkg

// ### emla_term_mem.sv
// Product-term store with registered read data
`timescale 1ns/1ps
`default_nettype none

module emla_term_mem import emla_pkg::*; #(
  parameter int W = EMLA_TERM_W,
  parameter int D = EMLA_TERMS,
  parameter int AW = EMLA_TERM_AW
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] rdata_q
);

  if (D > (1 << AW)) begin : g_chk
    $error("emla_term_mem: depth exceeds address range");
  end

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [W-1:0] rdata;
  } emla_mem_state_t;

  emla_mem_state_t s_q;
  emla_mem_state_t s_d;

  // Read before write on the same address
  always_comb begin
    s_d = s_q;
    s_d.rdata = s_q.mem[addr];
    if (we) begin
      s_d.mem[addr] = wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_q = s_q.rdata;

endmodule : emla_term_mem
`default_nettype wire

// ### emla_array_monitor.sv
// Port checker of the logic array
`timescale 1ns/1ps
`default_nettype none
module emla_array_monitor import emla_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [EMLA_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [EMLA_CELLS-1:0] io_pin_out,
  input wire logic [EMLA_CELLS-1:0] io_pin_oe
);
  typedef struct packed {
    logic [7:0] cnt;
    logic sec;
    logic sig_ok;
    logic [31:0] sig;
  } emla_mon_t;
  emla_mon_t mon_q;
  emla_mon_t mon_d;
  logic rd_ack;
  logic wr_ack;
  assign rd_ack = avs_read && !avs_waitrequest;
  assign wr_ack = avs_write && !avs_waitrequest;
  always_comb begin
    mon_d = mon_q;
    if (mon_q.cnt != 8'hC8) mon_d.cnt = mon_q.cnt + 8'h01;
    if (wr_ack && avs_address == EMLA_OFF_CTRL)
      mon_d.sec = mon_q.sec | avs_writedata[EMLA_CTRL_SECURE_BIT];
    if (wr_ack && avs_address == EMLA_OFF_SIG_LO) begin
      mon_d.sig_ok = 1'b1;
      mon_d.sig = avs_writedata;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) mon_q <= '0;
    else mon_q <= mon_d;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_req_up;
    $rose(avs_read || avs_write);
  endsequence
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  AST_BUS_WAIT:
    assert property (s_req_up |-> s_one_wait)
    else $error("bus answer not after one wait state");
  AST_BUS_ACK:
    assert property ((rd_ack || wr_ack) |-> $past(avs_waitrequest))
    else $error("bus answer without wait state");
  AST_PUR_OE:
    assert property (mon_q.cnt < EMLA_PUR_CYC |-> io_pin_oe == 8'h00)
    else $error("output enabled in power-up interval");
  AST_PUR_OUT:
    assert property (mon_q.cnt < EMLA_PUR_CYC |-> io_pin_out == 8'hFF)
    else $error("output low in power-up interval");
  AST_PUR_READY:
    assert property (rd_ack && avs_address == EMLA_OFF_STATUS
      && mon_q.cnt < 8'h60 |-> !avs_readdata[EMLA_ST_READY_BIT])
    else $error("ready shown in power-up interval");
  AST_SIG_LO:
    assert property (rd_ack && avs_address == EMLA_OFF_SIG_LO
      && mon_q.sig_ok |-> avs_readdata == mon_q.sig)
    else $error("signature low word lost");
  AST_SEC_ARR:
    assert property (rd_ack && avs_address == EMLA_OFF_ARR_DATA
      && mon_q.sec |-> avs_readdata == 32'h0)
    else $error("pattern readable while secured");
  AST_SEC_FLAG:
    assert property (rd_ack && avs_address == EMLA_OFF_STATUS
      && mon_q.sec |-> avs_readdata[EMLA_ST_SECURE_BIT])
    else $error("secure flag not shown");
endmodule : emla_array_monitor
bind emla_array emla_array_monitor u_mon (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .io_pin_out(io_pin_out),
  .io_pin_oe(io_pin_oe)
);
`default_nettype wire

// ### emla_board.sv
// Board model driving inputs, clock and enable pins
`timescale 1ns/1ps
`default_nettype none
module emla_board import emla_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [EMLA_CELLS-1:0] io_pin_out,
  input wire logic [EMLA_CELLS-1:0] io_pin_oe,
  output logic [EMLA_INPUTS-1:0] in_pin,
  output logic [EMLA_INPUTS-1:0] in_pin_driven,
  output logic clk_pin,
  output logic clk_pin_driven,
  output logic oe_n_pin,
  output logic oe_n_pin_driven,
  output logic [EMLA_CELLS-1:0] io_pin_in,
  output logic [EMLA_CELLS-1:0] io_pin_driven
);
  int up_cnt;
  // Undriven I/O floats to the pull-up level
  assign io_pin_in = (io_pin_oe & io_pin_out) | ~io_pin_oe;
  assign io_pin_driven = 8'h00;
  initial begin
    in_pin = 8'hFF;
    in_pin_driven = 8'h00;
    clk_pin = 1'b0;
    clk_pin_driven = 1'b1;
    oe_n_pin = 1'b1;
    oe_n_pin_driven = 1'b0;
  end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) up_cnt <= 0;
    else if (up_cnt < 1000) up_cnt <= up_cnt + 1;
  end
  task set_in(input logic [7:0] v, input logic [7:0] d);
    @(posedge clk_sys);
    in_pin <= v | ~d;
    in_pin_driven <= d;
  endtask : set_in
  task set_oe(input logic v, input logic d);
    @(posedge clk_sys);
    oe_n_pin <= v | ~d;
    oe_n_pin_driven <= d;
  endtask : set_oe
  task set_clk(input logic v);
    wait (up_cnt >= EMLA_PUR_CYC);
    @(posedge clk_sys);
    clk_pin <= v;
  endtask : set_clk
  task pulse_clk();
    repeat (150) @(posedge clk_sys);
    set_clk(1'b1);
    repeat (4) @(posedge clk_sys);
    set_clk(1'b0);
  endtask : pulse_clk
endmodule : emla_board
`default_nettype wire

// ### tb_top.sv
// Self-checking bench of the logic array
`timescale 1ns/1ps
`default_nettype none
module tb_top import emla_pkg::*; ();
  logic clk_sys;
  logic rst_n;
  logic [EMLA_AW-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] in_pin, in_pin_driven, io_pin_in, io_pin_driven;
  logic [7:0] io_pin_out, io_pin_oe;
  logic clk_pin, clk_pin_driven, oe_n_pin, oe_n_pin_driven;
  logic [31:0] r;
  logic [31:0] p;
  int bad_count;
  int checks_done;
  emla_array u_dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .in_pin(in_pin),
    .in_pin_driven(in_pin_driven),
    .clk_pin(clk_pin),
    .clk_pin_driven(clk_pin_driven),
    .oe_n_pin(oe_n_pin),
    .oe_n_pin_driven(oe_n_pin_driven),
    .io_pin_in(io_pin_in),
    .io_pin_driven(io_pin_driven),
    .io_pin_out(io_pin_out),
    .io_pin_oe(io_pin_oe)
  );
  emla_board u_board (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .io_pin_out(io_pin_out),
    .io_pin_oe(io_pin_oe),
    .in_pin(in_pin),
    .in_pin_driven(in_pin_driven),
    .clk_pin(clk_pin),
    .clk_pin_driven(clk_pin_driven),
    .oe_n_pin(oe_n_pin),
    .oe_n_pin_driven(oe_n_pin_driven),
    .io_pin_in(io_pin_in),
    .io_pin_driven(io_pin_driven)
  );
  task end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task term(input logic [5:0] t, input logic [31:0] v);
    bus(1'b1, EMLA_OFF_ARR_ADDR, {26'h0, t});
    bus(1'b1, EMLA_OFF_ARR_DATA, v);
  endtask : term
  task t_power();
    int n;
    n = 0;
    bus(1'b0, EMLA_OFF_STATUS, 32'h0);
    chk(r & 32'h00FF_FF03, 32'h0000_FF00);
    bus(1'b0, 5'h06, 32'h0);
    chk(r, 32'h0);
    do begin
      bus(1'b0, EMLA_OFF_STATUS, 32'h0);
      n++;
    end while (r[0] !== 1'b1 && n < 60);
    chk({23'h0, r[0], io_pin_out}, 32'h1FF);
  endtask : t_power
  task t_preload();
    u_board.set_oe(1'b0, 1'b1);
    bus(1'b1, EMLA_OFF_CTRL, 32'h0);
    bus(1'b1, EMLA_OFF_CELLCFG, 32'h0);
    bus(1'b1, EMLA_OFF_PLOAD, 32'hFFA5);
    bus(1'b0, EMLA_OFF_PLOAD, 32'h0);
    chk(r & 32'hFF, 32'hA5);
    repeat (5) @(posedge clk_sys);
    chk({16'h0, io_pin_oe, io_pin_out}, 32'hFF5A);
    bus(1'b1, EMLA_OFF_PLOAD, 32'h0F00);
    bus(1'b0, EMLA_OFF_PLOAD, 32'h0);
    chk(r & 32'hFF, 32'hA0);
    u_board.set_oe(1'b1, 1'b0);
    repeat (5) @(posedge clk_sys);
    chk({24'h0, io_pin_oe}, 32'h0);
    u_board.set_oe(1'b0, 1'b1);
  endtask : t_preload
  task t_clock();
    term(6'h00, 32'h1);
    term(6'h38, 32'h4000_0000);
    u_board.set_in(8'h00, 8'hFE);
    u_board.pulse_clk();
    repeat (4) @(posedge clk_sys);
    chk({24'h0, io_pin_out}, 32'h7E);
    bus(1'b0, EMLA_OFF_PLOAD, 32'h0);
    chk(r & 32'hFF, 32'h81);
    u_board.set_in(8'h00, 8'hFF);
    u_board.pulse_clk();
    repeat (4) @(posedge clk_sys);
    chk({24'h0, io_pin_out}, 32'h7F);
    term(6'h00, 32'h0);
    term(6'h38, 32'h0);
  endtask : t_clock
  task t_complex();
    bus(1'b1, EMLA_OFF_CTRL, 32'h1);
    bus(1'b1, EMLA_OFF_CELLCFG, 32'h0004);
    term(6'h08, 32'h4);
    term(6'h09, 32'h0001_0000);
    u_board.set_in(8'h02, 8'hFF);
    u_board.set_clk(1'b1);
    repeat (150) @(posedge clk_sys);
    chk({30'h0, io_pin_oe[1], io_pin_out[1]}, 32'h3);
    bus(1'b1, EMLA_OFF_CELLCFG, 32'h2_0004);
    repeat (150) @(posedge clk_sys);
    chk({30'h0, io_pin_oe[1], io_pin_out[1]}, 32'h2);
    u_board.set_clk(1'b0);
    repeat (150) @(posedge clk_sys);
    chk({30'h0, io_pin_oe[1], io_pin_out[1]}, 32'h3);
    u_board.set_in(8'h00, 8'hFF);
    repeat (150) @(posedge clk_sys);
    chk({31'h0, io_pin_oe[1]}, 32'h0);
    term(6'h08, 32'h0);
    term(6'h09, 32'h0);
  endtask : t_complex
  task t_simple();
    bus(1'b1, EMLA_OFF_CTRL, 32'h2);
    bus(1'b1, EMLA_OFF_CELLCFG, 32'h00C0);
    term(6'h18, 32'h0100_0000);
    u_board.set_oe(1'b1, 1'b1);
    repeat (150) @(posedge clk_sys);
    chk({30'h0, io_pin_oe[3], io_pin_out[3]}, 32'h3);
    u_board.set_oe(1'b0, 1'b1);
    repeat (150) @(posedge clk_sys);
    chk({30'h0, io_pin_oe[3], io_pin_out[3]}, 32'h2);
    term(6'h18, 32'h0);
  endtask : t_simple
  task t_secure();
    bus(1'b1, EMLA_OFF_CTRL, 32'h0);
    bus(1'b1, EMLA_OFF_CTRL, 32'h3);
    bus(1'b0, EMLA_OFF_CTRL, 32'h0);
    chk(r & 32'h3, 32'h0);
    term(6'h01, 32'h5);
    bus(1'b0, EMLA_OFF_ARR_DATA, 32'h0);
    chk(r, 32'h5);
    bus(1'b1, EMLA_OFF_SIG_LO, 32'h1234_5678);
    bus(1'b1, EMLA_OFF_SIG_HI, 32'h9ABC_DEF0);
    bus(1'b1, EMLA_OFF_CTRL, 32'h100);
    bus(1'b0, EMLA_OFF_ARR_DATA, 32'h0);
    chk(r, 32'h0);
    bus(1'b0, EMLA_OFF_STATUS, 32'h0);
    chk(r & 32'h2, 32'h2);
    bus(1'b0, EMLA_OFF_PLOAD, 32'h0);
    p = r & 32'hFF;
    bus(1'b1, EMLA_OFF_PLOAD, {16'h0, 8'hFF, ~p[7:0]});
    bus(1'b0, EMLA_OFF_PLOAD, 32'h0);
    chk(r & 32'hFF, p);
    bus(1'b0, EMLA_OFF_SIG_HI, 32'h0);
    chk(r, 32'h9ABC_DEF0);
    bus(1'b1, EMLA_OFF_SIG_LO, 32'hCAFE_0001);
    bus(1'b0, EMLA_OFF_SIG_LO, 32'h0);
    chk(r, 32'hCAFE_0001);
  endtask : t_secure
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    bad_count = 0;
    checks_done = 0;
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_power();
    for (int t = 0; t < EMLA_TERMS; t++) term(t[5:0], 32'h0);
    t_preload();
    t_clock();
    t_complex();
    t_simple();
    t_secure();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
